// ==== src/siotm_pkg.sv ====
package siotm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TERM_LO = 8'h04;
    localparam logic [7:0] OFF_TERM_HI = 8'h08;
    localparam logic [7:0] OFF_MON_SEL = 8'h0C;
    localparam logic [7:0] OFF_PULSE_GAIN = 8'h10;
    localparam logic [7:0] OFF_VOLT_ADJ = 8'h14;
    localparam logic [7:0] OFF_CUR_ADJ = 8'h18;
    localparam logic [7:0] OFF_AIN_VOLT_ADJ = 8'h1C;
    localparam logic [7:0] OFF_AIN_CUR_ADJ = 8'h20;
    localparam logic [7:0] OFF_AIN_BIP_ADJ = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;
    localparam logic [7:0] OFF_AIN_VOLT = 8'h2C;
    localparam logic [7:0] OFF_AIN_CUR = 8'h30;
    localparam logic [7:0] OFF_AIN_BIP = 8'h34;
    // Field positions
    localparam int CTRL_SEQ_EN_BIT = 0;
    localparam int ADJ_GAIN_LSB = 0;
    localparam int ADJ_BIAS_LSB = 16;
    localparam int SEL_PULSE_LSB = 0;
    localparam int SEL_VOLT_LSB = 8;
    localparam int SEL_CUR_LSB = 16;
    // Reset values: gain 1.0 in Q10, bias zero
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_TERM = 32'h0000_0000;
    localparam logic [31:0] RST_MON_SEL = 32'h0000_0000;
    localparam logic [31:0] RST_ADJ = 32'h0000_0400;
    localparam int GAIN_SHIFT = 10;
    // Function and selector codes
    localparam logic [7:0] FN_GP_FIRST = 8'h2C;
    localparam logic [7:0] FN_GP_LAST = 8'h31;
    localparam logic [7:0] SEQ_ENABLE_CODE = 8'h01;
    localparam logic [7:0] PULSE_SEL_PROGRAM_CODE = 8'h0C;
    localparam logic [7:0] VOLT_SEL_PROGRAM_CODE = 8'h0D;
    localparam logic [7:0] CURRENT_SEL_PROGRAM_CODE = 8'h0E;
    // Legal selector codes, one bit per code
    localparam logic [15:0] PULSE_SEL_MASK = 16'h17FF;
    localparam logic [15:0] VOLT_SEL_MASK = 16'h2EF7;
    localparam logic [15:0] CUR_SEL_MASK = 16'h46F7;
    // Value ranges
    localparam logic signed [16:0] VAR_MAX = 17'sh0_2710;
    localparam logic signed [16:0] VAR_MIN_BIP = -17'sh0_2710;
    localparam logic signed [16:0] VAR_ZERO = 17'sh0_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : siotm_pkg

// ==== src/siotm_terminal_map.sv ====
`timescale 1ns/1ns
// How it works
// - Codes 44..49 map output bits 0..5 to any terminal.
// - Terminal shows its output bit.
// - Sequence off or outputs unused: such terminals inactive.
// - Other functions keep working while a program runs.
// - Voltage input value 0 to 10000.
// - Current input value 0 to 10000.
// - Bipolar input value -10000 to 10000.
// - Inputs always readable, no setup.
// - Each input uses its own adjustment.
// - Pulse selector 12 takes analog variable zero.
// - Pulse output scaled by gain.
// - Voltage selector 13 takes analog variable one.
// - Voltage monitor gain and bias.
// - Current selector 14 takes analog variable two.
// - Current monitor gain and bias.
// - Pulse selector codes 00..10 and 12.
// - Voltage selector codes 00-02,04-07,09-11,13.
// - Current selector codes 00-02,04-07,09,10,14.
// - Enable 01 turns sequence on; forward pin becomes run.
// - Run input low stops program, commands off.
module siotm_terminal_map #(
    parameter int PHASE_W = 24,
    parameter int SRC_N = 12
) (
    input wire logic sys_clk, // 250 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic forwardRunInput, // Forward/run pin
    input wire logic [15:0] voltAnalogIn, // Voltage converter code
    input wire logic [15:0] currentAnalogIn, // Current converter code
    input wire logic [15:0] bipolarAnalogIn, // Bipolar converter code
    input wire logic progOutUsed, // Program references outputs
    input wire logic progBitWe, // Single-bit output write
    input wire logic [2:0] progBitIdx, // Single-bit index
    input wire logic progBitVal, // Single-bit value
    input wire logic progWordWe, // Packed word write
    input wire logic [5:0] progWordData, // Packed word value
    input wire logic progAoutWe, // Analog variable write
    input wire logic [1:0] progAoutIdx, // Analog variable index
    input wire logic [15:0] progAoutData, // Analog variable value
    input wire logic [63:0] fnState, // Other terminal functions
    input wire logic [SRC_N-1:0][15:0] monSource, // Monitor sources
    output logic [4:0] outTerm, // Output terminals
    output logic relayOut, // Alarm relay
    output logic fwdRunCmd, // Forward run command
    output logic cmdInhibit, // Force run commands off
    output logic programRun, // Program runs
    output logic [15:0] analogInVoltValue, // Program voltage value
    output logic [15:0] analogInCurrentValue, // Program current value
    output logic [15:0] analogInBipolarValue, // Program bipolar value
    output logic pulseMonitorOut, // Pulse monitor
    output logic [15:0] voltageMonitorOut, // Voltage monitor code
    output logic [15:0] currentMonitorOut // Current monitor code
);

    // Gain in Q10, then bias, then clamp
    function automatic logic signed [16:0] scale_sat(
        input logic signed [16:0] v,
        input logic [15:0] gain,
        input logic signed [15:0] bias,
        input logic signed [16:0] lo
    );
        logic signed [34:0] p;
        p = v * $signed({1'b0, gain});
        p = (p >>> siotm_pkg::GAIN_SHIFT) + 35'(bias);
        if (p > 35'(siotm_pkg::VAR_MAX))
            return siotm_pkg::VAR_MAX;
        else if (p < 35'(lo))
            return lo;
        return p[16:0];
    endfunction : scale_sat

    // Source select: illegal codes give zero
    function automatic logic signed [16:0] pick(
        input logic [7:0] code,
        input logic [15:0] mask,
        input logic [7:0] progCode,
        input logic [15:0] progVal,
        input logic [SRC_N-1:0][15:0] src
    );
        logic signed [16:0] r;
        r = siotm_pkg::VAR_ZERO;
        if (code == progCode)
            r = $signed({1'b0, progVal});
        else if (code < 8'(SRC_N) && mask[code[3:0]])
            r = 17'($signed(src[code[3:0]]));
        return r;
    endfunction : pick

    logic [1:0] rstPipe;
    logic rstN;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rstPipe <= 2'b00;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstN = rstPipe[1];

    // Pin synchronisers, first stage read only by second
    logic [1:0] fwSync;
    logic [15:0] vMeta, vSync, cMeta, cSync, bMeta, bSync;
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            fwSync <= 2'b00;
            {vMeta, vSync, cMeta, cSync, bMeta, bSync} <= 96'h0;
        end
        else
        begin
            fwSync <= {fwSync[0], forwardRunInput};
            vMeta <= voltAnalogIn;
            vSync <= vMeta;
            cMeta <= currentAnalogIn;
            cSync <= cMeta;
            bMeta <= bipolarAnalogIn;
            bSync <= bMeta;
        end
    end

    // Register file
    logic [31:0] ctrl, termLo, termHi, monSel, pulseGain;
    logic [31:0] voltAdj, curAdj, ainVAdj, ainCAdj, ainBAdj;
    logic [31:0] next_ctrl, next_termLo, next_termHi, next_monSel;
    logic [31:0] next_pulseGain, next_voltAdj, next_curAdj;
    logic [31:0] next_ainVAdj, next_ainCAdj, next_ainBAdj;
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic awHeld, wHeld, next_awHeld, next_wHeld;
    logic bValid, next_bValid, rValid, next_rValid;
    logic [1:0] bResp, next_bResp, rResp, next_rResp;
    logic [31:0] rData, next_rData, rdMux;
    logic rdHit, doWrite;
    logic [31:0] status;
    logic [5:0] outBits, next_outBits;
    logic [2:0][15:0] aoutVar, next_aoutVar;
    logic signed [16:0] ainV, ainC, ainB;
    logic [7:0] selPulse, selVolt, selCur;
    logic seqEnable, runNow;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0] s
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction : merge

    // Write takes address and data in either order
    assign s_axi_awready = !awHeld && !bValid;
    assign s_axi_wready = !wHeld && !bValid;
    assign doWrite = awHeld && wHeld && !bValid;
    assign s_axi_arready = !rValid;

    // Write channel and register next values
    always_comb
    begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bValid = bValid;
        next_bResp = bResp;
        next_ctrl = ctrl;
        next_termLo = termLo;
        next_termHi = termHi;
        next_monSel = monSel;
        next_pulseGain = pulseGain;
        next_voltAdj = voltAdj;
        next_curAdj = curAdj;
        next_ainVAdj = ainVAdj;
        next_ainCAdj = ainCAdj;
        next_ainBAdj = ainBAdj;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (bValid && s_axi_bready)
            next_bValid = 1'b0;
        if (doWrite)
        begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bValid = 1'b1;
            next_bResp = siotm_pkg::RESP_OKAY;
            case ({awAddr[7:2], 2'b00})
                siotm_pkg::OFF_CTRL:
                    next_ctrl = merge(ctrl, wData, wStrb);
                siotm_pkg::OFF_TERM_LO:
                    next_termLo = merge(termLo, wData, wStrb);
                siotm_pkg::OFF_TERM_HI:
                    next_termHi = merge(termHi, wData, wStrb);
                siotm_pkg::OFF_MON_SEL:
                    next_monSel = merge(monSel, wData, wStrb);
                siotm_pkg::OFF_PULSE_GAIN:
                    next_pulseGain = merge(pulseGain, wData, wStrb);
                siotm_pkg::OFF_VOLT_ADJ:
                    next_voltAdj = merge(voltAdj, wData, wStrb);
                siotm_pkg::OFF_CUR_ADJ:
                    next_curAdj = merge(curAdj, wData, wStrb);
                siotm_pkg::OFF_AIN_VOLT_ADJ:
                    next_ainVAdj = merge(ainVAdj, wData, wStrb);
                siotm_pkg::OFF_AIN_CUR_ADJ:
                    next_ainCAdj = merge(ainCAdj, wData, wStrb);
                siotm_pkg::OFF_AIN_BIP_ADJ:
                    next_ainBAdj = merge(ainBAdj, wData, wStrb);
                siotm_pkg::OFF_STATUS, siotm_pkg::OFF_AIN_VOLT,
                siotm_pkg::OFF_AIN_CUR, siotm_pkg::OFF_AIN_BIP:
                    next_bResp = siotm_pkg::RESP_OKAY;
                default:
                    next_bResp = siotm_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Read decode; status words are read-only
    always_comb
    begin
        rdHit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            siotm_pkg::OFF_CTRL: rdMux = ctrl;
            siotm_pkg::OFF_TERM_LO: rdMux = termLo;
            siotm_pkg::OFF_TERM_HI: rdMux = termHi;
            siotm_pkg::OFF_MON_SEL: rdMux = monSel;
            siotm_pkg::OFF_PULSE_GAIN: rdMux = pulseGain;
            siotm_pkg::OFF_VOLT_ADJ: rdMux = voltAdj;
            siotm_pkg::OFF_CUR_ADJ: rdMux = curAdj;
            siotm_pkg::OFF_AIN_VOLT_ADJ: rdMux = ainVAdj;
            siotm_pkg::OFF_AIN_CUR_ADJ: rdMux = ainCAdj;
            siotm_pkg::OFF_AIN_BIP_ADJ: rdMux = ainBAdj;
            siotm_pkg::OFF_STATUS: rdMux = status;
            siotm_pkg::OFF_AIN_VOLT: rdMux = {16'h0000, analogInVoltValue};
            siotm_pkg::OFF_AIN_CUR: rdMux = {16'h0000, analogInCurrentValue};
            siotm_pkg::OFF_AIN_BIP: rdMux = {16'h0000, analogInBipolarValue};
            default:
            begin
                rdMux = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
        next_rValid = rValid;
        next_rData = rData;
        next_rResp = rResp;
        if (rValid && s_axi_rready)
            next_rValid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rValid = 1'b1;
            next_rData = rdMux;
            next_rResp = rdHit ? siotm_pkg::RESP_OKAY : siotm_pkg::RESP_SLVERR;
        end
    end

    // Bus and register flops
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            {awHeld, wHeld, bValid, rValid} <= 4'h0;
            {awAddr, wData, wStrb, rData} <= 76'h0;
            bResp <= siotm_pkg::RESP_OKAY;
            rResp <= siotm_pkg::RESP_OKAY;
            ctrl <= siotm_pkg::RST_CTRL;
            termLo <= siotm_pkg::RST_TERM;
            termHi <= siotm_pkg::RST_TERM;
            monSel <= siotm_pkg::RST_MON_SEL;
            {pulseGain, voltAdj, curAdj, ainVAdj, ainCAdj, ainBAdj} <=
                {6{siotm_pkg::RST_ADJ}};
        end
        else
        begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            bValid <= next_bValid;
            bResp <= next_bResp;
            rValid <= next_rValid;
            rData <= next_rData;
            rResp <= next_rResp;
            ctrl <= next_ctrl;
            termLo <= next_termLo;
            termHi <= next_termHi;
            monSel <= next_monSel;
            pulseGain <= next_pulseGain;
            voltAdj <= next_voltAdj;
            curAdj <= next_curAdj;
            ainVAdj <= next_ainVAdj;
            ainCAdj <= next_ainCAdj;
            ainBAdj <= next_ainBAdj;
        end
    end
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_rvalid = rValid;
    assign s_axi_rdata = rData;
    assign s_axi_rresp = rResp;

    assign seqEnable = ctrl[7:0] == siotm_pkg::SEQ_ENABLE_CODE;
    assign runNow = seqEnable && fwSync[1];
    assign status = {24'h00_0000, outBits, runNow, seqEnable};

    // Program variables; word and bit share one state
    always_comb
    begin
        next_outBits = outBits;
        next_aoutVar = aoutVar;
        if (progWordWe)
            next_outBits = progWordData;
        if (progBitWe && progBitIdx < 3'd6)
            next_outBits[progBitIdx] = progBitVal;
        if (progAoutWe && progAoutIdx != 2'd3)
            next_aoutVar[progAoutIdx] =
                (progAoutData > 16'(siotm_pkg::VAR_MAX)) ?
                16'(siotm_pkg::VAR_MAX) : progAoutData;
    end

    // Analog input conditioning, always available to the program
    // voltage 0..10000
    assign ainV = scale_sat($signed({1'b0, vSync}), ainVAdj[15:0],
        $signed(ainVAdj[31:16]), siotm_pkg::VAR_ZERO);
    assign ainC = scale_sat($signed({1'b0, cSync}), ainCAdj[15:0],
        $signed(ainCAdj[31:16]), siotm_pkg::VAR_ZERO);
    assign ainB = scale_sat(17'($signed(bSync)), ainBAdj[15:0],
        $signed(ainBAdj[31:16]), siotm_pkg::VAR_MIN_BIP);

    // Monitor selection
    assign selPulse = monSel[siotm_pkg::SEL_PULSE_LSB +: 8];
    assign selVolt = monSel[siotm_pkg::SEL_VOLT_LSB +: 8];
    assign selCur = monSel[siotm_pkg::SEL_CUR_LSB +: 8];

    logic signed [16:0] pulseSrc, voltSrc, curSrc, pulseFreq;
    logic signed [16:0] voltVal, curVal;
    logic [PHASE_W-1:0] phase, next_phase;
    assign pulseSrc = pick(selPulse, siotm_pkg::PULSE_SEL_MASK,
        siotm_pkg::PULSE_SEL_PROGRAM_CODE, aoutVar[0], monSource);
    assign voltSrc = pick(selVolt, siotm_pkg::VOLT_SEL_MASK,
        siotm_pkg::VOLT_SEL_PROGRAM_CODE, aoutVar[1], monSource);
    assign curSrc = pick(selCur, siotm_pkg::CUR_SEL_MASK,
        siotm_pkg::CURRENT_SEL_PROGRAM_CODE, aoutVar[2], monSource);
    assign pulseFreq = scale_sat(pulseSrc, pulseGain[15:0], 16'sh0000,
        siotm_pkg::VAR_ZERO);
    assign voltVal = scale_sat(voltSrc, voltAdj[15:0],
        $signed(voltAdj[31:16]), siotm_pkg::VAR_MIN_BIP);
    assign curVal = scale_sat(curSrc, curAdj[15:0],
        $signed(curAdj[31:16]), siotm_pkg::VAR_ZERO);

    // Phase accumulator; pulse rate tracks the scaled value
    assign next_phase = phase + PHASE_W'(pulseFreq[15:0]);

    // Terminal function decode, one per terminal and the relay
    logic [5:0] termOut, next_termOut;
    logic [5:0][7:0] termCode;
    assign termCode = {termHi[15:0], termLo};
    for (genvar t = 0; t < 6; t++)
    begin : g_term
        always_comb
        begin
            if (termCode[t] >= siotm_pkg::FN_GP_FIRST &&
                termCode[t] <= siotm_pkg::FN_GP_LAST)
                next_termOut[t] = runNow && progOutUsed &&
                    outBits[3'(termCode[t] - siotm_pkg::FN_GP_FIRST)];
            else
                next_termOut[t] = termCode[t] < 8'd64 &&
                    fnState[termCode[t][5:0]];
        end
    end

    // Output and variable flops
    always_ff @(posedge sys_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            outBits <= 6'h00;
            aoutVar <= '0;
            phase <= '0;
            termOut <= 6'h00;
            {analogInVoltValue, analogInCurrentValue} <= 32'h0;
            analogInBipolarValue <= 16'h0000;
            {voltageMonitorOut, currentMonitorOut} <= 32'h0;
        end
        else
        begin
            outBits <= next_outBits;
            aoutVar <= next_aoutVar;
            phase <= next_phase;
            termOut <= next_termOut;
            analogInVoltValue <= ainV[15:0];
            analogInCurrentValue <= ainC[15:0];
            analogInBipolarValue <= ainB[15:0];
            voltageMonitorOut <= voltVal[15:0];
            currentMonitorOut <= curVal[15:0];
        end
    end

    assign outTerm = termOut[4:0];
    assign relayOut = termOut[5];
    assign pulseMonitorOut = phase[PHASE_W-1];
    assign programRun = runNow;
    // forward pin lost to run input
    assign fwdRunCmd = !seqEnable && fwSync[1];
    assign cmdInhibit = seqEnable && !fwSync[1];

endmodule : siotm_terminal_map

// ==== tb/siotm_asserts.sv ====
`timescale 1ns/1ns
module siotm_asserts (
    input wire logic sys_clk, // Clock
    input wire logic nrst, // Reset, low
    input wire logic s_axi_bvalid, // Write answer
    input wire logic s_axi_bready, // Answer taken
    input wire logic s_axi_rvalid, // Read answer
    input wire logic s_axi_rready, // Answer taken
    input wire logic fwdRunCmd, // Forward command
    input wire logic cmdInhibit, // Commands off
    input wire logic programRun, // Program runs
    input wire logic [15:0] analogInVoltValue, // Voltage value
    input wire logic [15:0] analogInCurrentValue, // Current value
    input wire logic [15:0] analogInBipolarValue // Bipolar value
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Run pin falls while sequence on
    sequence stopEdge;
        $rose(cmdInhibit);
    endsequence
    AST_STOP: assert property (stopEdge |-> !programRun && !fwdRunCmd)
        else $error("stop left a command on");
    AST_EXCL: assert property (!(cmdInhibit && programRun))
        else $error("inhibit and run together");
    AST_FWD_OFF: assert property (programRun |-> !fwdRunCmd)
        else $error("forward command while program runs");
    AST_VOLT: assert property (analogInVoltValue <= 16'h2710)
        else $error("voltage value above range");
    AST_CUR: assert property (analogInCurrentValue <= 16'h2710)
        else $error("current value above range");
    AST_BIP: assert property ($signed(analogInBipolarValue) >= -16'sh2710 && $signed(analogInBipolarValue) <= 16'sh2710)
        else $error("bipolar value out of range");
    // One read and one write at a time
    AST_RD_CLEAR: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not cleared");
    AST_WR_CLEAR: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not cleared");
endmodule : siotm_asserts
bind siotm_terminal_map siotm_asserts chk_u (.sys_clk, .nrst, .s_axi_bvalid,
    .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .fwdRunCmd, .cmdInhibit,
    .programRun, .analogInVoltValue, .analogInCurrentValue,
    .analogInBipolarValue);

// ==== tb/siotm_prog_model.sv ====
`timescale 1ns/1ns
module siotm_prog_model (
    input wire logic sys_clk, // Clock
    output logic progOutUsed, // Outputs referenced
    output logic progBitWe, // Bit write
    output logic [2:0] progBitIdx, // Bit index
    output logic progBitVal, // Bit value
    output logic progWordWe, // Word write
    output logic [5:0] progWordData, // Word value
    output logic progAoutWe, // Analog write
    output logic [1:0] progAoutIdx, // Analog index
    output logic [15:0] progAoutData // Analog value
);
    // Idle program, nothing pending
    initial
    begin
        {progOutUsed, progBitWe, progBitIdx, progBitVal, progWordWe} = 0;
        {progWordData, progAoutWe, progAoutIdx, progAoutData} = 0;
    end
    // Strobes last one cycle; set after the edge
    task automatic setUse(input logic u);
        @(posedge sys_clk);
        progOutUsed <= u;
    endtask : setUse
    task automatic bitWr(input logic [2:0] i, input logic v);
        @(posedge sys_clk);
        {progBitWe, progBitIdx, progBitVal} <= {1'b1, i, v};
        @(posedge sys_clk);
        progBitWe <= 1'b0;
    endtask : bitWr
    task automatic wordWr(input logic [5:0] d);
        @(posedge sys_clk);
        {progWordWe, progWordData} <= {1'b1, d};
        @(posedge sys_clk);
        progWordWe <= 1'b0;
    endtask : wordWr
    task automatic aoutWr(input logic [1:0] i, input logic [15:0] d);
        @(posedge sys_clk);
        {progAoutWe, progAoutIdx, progAoutData} <= {1'b1, i, d};
        @(posedge sys_clk);
        progAoutWe <= 1'b0;
    endtask : aoutWr
endmodule : siotm_prog_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    logic sys_clk = 0;
    logic nrst = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, forwardRunInput = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [15:0] voltAnalogIn = 0, currentAnalogIn = 0, bipolarAnalogIn = 0;
    logic [63:0] fnState = 0;
    logic [11:0][15:0] monSource = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, relayOut, fwdRunCmd, cmdInhibit, programRun;
    logic pulseMonitorOut;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, progAoutIdx;
    logic [4:0] outTerm;
    logic [15:0] analogInVoltValue, analogInCurrentValue, analogInBipolarValue;
    logic [15:0] voltageMonitorOut, currentMonitorOut, progAoutData;
    logic progOutUsed, progBitWe, progBitVal, progWordWe, progAoutWe;
    logic [2:0] progBitIdx;
    logic [5:0] progWordData;
    int errors = 0, n_checks = 0, cyc = 0;
    siotm_terminal_map dut_u (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .forwardRunInput,
        .voltAnalogIn, .currentAnalogIn, .bipolarAnalogIn, .progOutUsed,
        .progBitWe, .progBitIdx, .progBitVal, .progWordWe, .progWordData,
        .progAoutWe, .progAoutIdx, .progAoutData, .fnState, .monSource,
        .outTerm, .relayOut, .fwdRunCmd, .cmdInhibit, .programRun,
        .analogInVoltValue, .analogInCurrentValue, .analogInBipolarValue,
        .pulseMonitorOut, .voltageMonitorOut, .currentMonitorOut);
    siotm_prog_model prog_u (.sys_clk, .progOutUsed, .progBitWe, .progBitIdx,
        .progBitVal, .progWordWe, .progWordData, .progAoutWe, .progAoutIdx,
        .progAoutData);
    initial forever #2 sys_clk = ~sys_clk;
    // Hang guard, well above the run length
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n, input string s);
        repeat (n) @(posedge sys_clk);
        $display("test %s done", s);
    endtask : step
    // Called just after an edge; ready and answer taken at the rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
    endtask : rd
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        step(4, "reset");
        chk(pulseMonitorOut, 1'b0);
        rd(siotm_pkg::OFF_PULSE_GAIN);
        chk(d, 32'h0000_0400);
        rd(8'h40);
        chk(r, siotm_pkg::RESP_SLVERR);
        wr(siotm_pkg::OFF_TERM_LO, 32'h2F2E_2D2C);
        wr(siotm_pkg::OFF_TERM_HI, 32'h0000_3130);
        prog_u.setUse(1'b1);
        prog_u.wordWr(6'h3F);
        step(3, "sequence off");
        chk({relayOut, outTerm}, 6'h00);
        wr(siotm_pkg::OFF_CTRL, 32'h0000_0001);
        forwardRunInput <= 1'b1;
        step(4, "enable");
        chk(programRun, 1'b1);
        chk(fwdRunCmd, 1'b0);
        prog_u.wordWr(6'h2A);
        step(3, "word");
        chk({relayOut, outTerm}, 6'h2A);
        prog_u.bitWr(3'h0, 1'b1);
        step(3, "bit");
        chk({relayOut, outTerm}, 6'h2B);
        prog_u.setUse(1'b0);
        step(3, "unused");
        chk({relayOut, outTerm}, 6'h00);
        prog_u.setUse(1'b1);
        prog_u.wordWr(6'h00);
        fnState <= 64'h20;
        wr(siotm_pkg::OFF_TERM_LO, 32'h2F2E_2D05);
        step(3, "other function");
        chk({relayOut, outTerm}, 6'h01);
        voltAnalogIn <= 16'h2EE0;
        currentAnalogIn <= 16'h01F4;
        bipolarAnalogIn <= 16'hD120;
        step(5, "inputs");
        chk(analogInVoltValue, 16'h2710);
        chk(analogInCurrentValue, 16'h01F4);
        chk(analogInBipolarValue, 16'hD8F0);
        rd(siotm_pkg::OFF_AIN_VOLT);
        chk(d, 32'h0000_2710);
        wr(siotm_pkg::OFF_AIN_CUR_ADJ, 32'h0000_0200);
        step(5, "adjust");
        chk(analogInCurrentValue, 16'h00FA);
        wr(siotm_pkg::OFF_MON_SEL, 32'h000E_0D0C);
        wr(siotm_pkg::OFF_VOLT_ADJ, 32'h0064_0200);
        prog_u.aoutWr(2'h1, 16'h2EE0);
        prog_u.aoutWr(2'h2, 16'h012C);
        step(3, "monitors");
        chk(voltageMonitorOut, 16'h13EC);
        chk(currentMonitorOut, 16'h012C);
        monSource[0] <= 16'h0123;
        wr(siotm_pkg::OFF_MON_SEL, 32'h0000_0D0C);
        step(3, "source");
        chk(currentMonitorOut, 16'h0123);
        forwardRunInput <= 1'b0;
        step(4, "stop");
        chk(cmdInhibit, 1'b1);
        chk(programRun, 1'b0);
        tally_and_finish();
    end
endmodule : tb_top
